// ==== hw/led_dim_dev.sv ====
// Device end: sink gating, trim scaling, sleep, short detection and fault latch
`include "led_dim_regs.svh"
module led_dim_dev #(
	parameter int LOW_TIMEOUT = `LOW_TIMEOUT_CYC,
	parameter int SETTLE      = `SETTLE_CYC,
	parameter bit ALT_VARIANT = 1'b0
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Pins
	led_dim_if.device         pins,
	// Analog comparator flags per sink channel (asynchronous)
	input  wire led_dim_pkg::chan_t pin_above_short,
	input  wire led_dim_pkg::chan_t pin_in_reg,
	// Power stage controls
	output led_dim_pkg::chan_t sink_en,
	output logic              boost_en,
	output logic              bias_en,
	output logic              soft_start,
	output led_dim_pkg::level_t current_pct,
	output led_dim_pkg::pwr_state_t pwr_state
);
	import led_dim_pkg::*;
	logic [1:0]  act_s, gate_s, trim_s;
	chan_t       shr_a, shr_b, reg_a, reg_b;
	logic [31:0] act_low_r, gate_low_r;
	logic [11:0] lead_r;
	logic        gate_d_r, tail_r, lead_done_r;
	pwr_state_t  st_r, st_nxt;
	logic [9:0]  soft_r;
	chan_t       off_r;
	logic        fault_r;
	logic [15:0] win_r, hi_cnt_r;
	level_t      target_r, cur_r;
	logic [31:0] settle_r;
	logic [5:0]  mir_cnt_r;
	logic        mir_r;
	// Two-flop synchronisers on all pins and comparator flags
	always_ff @(posedge core_clk) begin
		if (rst) begin
			act_s  <= '0;
			gate_s <= '0;
			trim_s <= '0;
			shr_a  <= '0;
			shr_b  <= '0;
			reg_a  <= '0;
			reg_b  <= '0;
		end else begin
			act_s  <= {act_s[0], pins.chip_activate};
			gate_s <= {gate_s[0], pins.dim_gate};
			trim_s <= {trim_s[0], pins.analog_trim_pulse_input}; // low means full
			shr_a  <= pin_above_short;
			shr_b  <= shr_a;
			reg_a  <= pin_in_reg;
			reg_b  <= reg_a;
		end
	end
	wire act  = act_s[1];
	wire gate = gate_s[1] & act;
	// Long low timers restart on any high
	wire act_timeout  = (act_low_r == 32'(LOW_TIMEOUT - 1));
	wire gate_timeout = (gate_low_r == 32'(LOW_TIMEOUT - 1));
	always_ff @(posedge core_clk) begin
		if (rst) begin
			act_low_r  <= '0;
			gate_low_r <= '0;
		end else begin
			act_low_r  <= act ? '0 : (act_timeout ? act_low_r : act_low_r + 32'h1);
			gate_low_r <= (gate_s[1] | ~act) ? '0 :
				(gate_timeout ? gate_low_r : gate_low_r + 32'h1);
		end
	end
	wire act_exp  = (act_low_r == 32'(LOW_TIMEOUT - 2));
	wire gate_exp = (gate_low_r == 32'(LOW_TIMEOUT - 2)) & act;
	wire fault_clr = act_exp | gate_exp;
	// Power state: sleep, idle, soft start, run
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_SLEEP: if (act) st_nxt = ST_IDLE;
			ST_IDLE:  if (gate) st_nxt = ST_SOFT;
			ST_SOFT:  if (soft_r == 10'(`SOFT_START_CYC - 1)) st_nxt = ST_RUN;
			ST_RUN:   if (gate_exp) st_nxt = ST_IDLE;
		endcase
		if (act_exp) st_nxt = ST_SLEEP;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r   <= ST_SLEEP;
			soft_r <= '0;
		end else begin
			st_r   <= st_nxt;
			soft_r <= (st_r == ST_SOFT) ? soft_r + 10'h001 : '0;
		end
	end
	// Lead time: boost on at gate rise, sinks after lead, both held lead after fall
	wire gate_rise = gate & ~gate_d_r;
	wire gate_fall = ~gate & gate_d_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gate_d_r    <= 1'b0;
			lead_r      <= '0;
			lead_done_r <= 1'b0;
			tail_r      <= 1'b0;
		end else begin
			gate_d_r <= gate;
			if (gate_rise | gate_fall) begin
				lead_r      <= 12'(`LEAD_CYC);
				lead_done_r <= 1'b0;
			end else if (lead_r != 12'h000) begin
				lead_r <= lead_r - 12'h001;
			end else begin
				lead_done_r <= gate;
			end
			if (gate_fall) tail_r <= lead_done_r | (lead_r != 12'h000);
			else if (lead_r == 12'h001 | gate) tail_r <= 1'b0;
		end
	end
	wire stage_on = (st_r != ST_SLEEP) & (st_r != ST_IDLE);
	// Tail covers the fall cycle itself, before tail_r is loaded
	wire tail_now = tail_r | (gate_fall & (lead_done_r | (lead_r != 12'h000)));
	wire sink_win = (gate & lead_done_r) | tail_now;
	// Short detection and per-channel latch
	wire       any_reg = |reg_b;
	wire chan_t new_sh = (sink_win & any_reg) ? shr_b : 4'h0;
	always_ff @(posedge core_clk) begin
		if (rst | (st_r == ST_SLEEP & act)) begin
			off_r   <= '0;
			fault_r <= 1'b0;
		end else if (fault_clr & ~(|new_sh)) begin
			off_r   <= '0;
			fault_r <= 1'b0;
		end else begin
			off_r   <= off_r | new_sh; // set wins over clear
			fault_r <= fault_r | ((|new_sh) & ~ALT_VARIANT);
		end
	end
	// Trim duty measured over a fixed window
	always_ff @(posedge core_clk) begin
		if (rst) begin
			win_r    <= '0;
			hi_cnt_r <= '0;
			target_r <= 8'h64;
		end else if (win_r == 16'(`TRIM_WIN_CYC - 1)) begin
			win_r    <= '0;
			hi_cnt_r <= '0;
			target_r <= 8'(8'h64 - 8'(32'(hi_cnt_r) * 100 / `TRIM_WIN_CYC));
		end else begin
			win_r    <= win_r + 16'h0001;
			hi_cnt_r <= hi_cnt_r + 16'(trim_s[1]);
		end
	end
	// Current ramps one percent per step to settle within the bound
	always_ff @(posedge core_clk) begin
		if (rst) begin
			settle_r <= '0;
			cur_r    <= 8'h64;
		end else if (settle_r >= 32'(SETTLE / 100)) begin
			settle_r <= '0;
			if (cur_r < target_r) cur_r <= cur_r + 8'h01;
			else if (cur_r > target_r) cur_r <= cur_r - 8'h01;
		end else begin
			settle_r <= settle_r + 32'h1;
		end
	end
	// Clock mirror runs whenever activate is high
	always_ff @(posedge core_clk) begin
		if (rst | ~act) begin
			mir_cnt_r <= '0;
			mir_r     <= 1'b0;
		end else if (mir_cnt_r == 6'(`CLK_MIRROR_HALF - 1)) begin
			mir_cnt_r <= '0;
			mir_r     <= ~mir_r;
		end else begin
			mir_cnt_r <= mir_cnt_r + 6'h01;
		end
	end
	assign sink_en     = (stage_on & sink_win) ? ~off_r : 4'h0;
	assign boost_en    = stage_on & (gate | tail_now);
	assign bias_en     = act | (st_r != ST_SLEEP);
	assign soft_start  = (st_r == ST_SOFT);
	assign current_pct = cur_r;
	assign pwr_state   = st_r;
	assign pins.fault_n_out         = 1'b0;
	assign pins.fault_n_oe          = fault_r;
	assign pins.clock_mirror_output = mir_r;
endmodule

// ==== hw/led_dim_regs.svh ====
// Timing constants and rule summary for the LED dimming and fault control block
// What this block does
// - Current fraction equals one hundred minus trim duty
// - Host drives trim pulses at 40 kHz to 1 MHz; here the host is fixed at 200 kHz by HOST_TRIM_PERIOD
// - Trim input pulled down gives full current
// - Current settles within half a millisecond
// - Host extends range with minimum gate, trim up to 90%
// - Trim source needs 50 ns resolution at 200 kHz
// - Host tunes lead time from 2.5 to 4 us; here lead is fixed at 3 us by LEAD_NS, with no host control
// - Activate low over 16 ms enters sleep
// - Wake clears faults, soft start on gate high
// - Gate low over 16 ms clears faults, no sleep
// - After gate clear, next gate rise soft starts
// - Bias and clock mirror run while activate high
// - Channel above short threshold leaves regulation
// - Standard variant drives error indicator low on short
// - Indicator stays latched until a 16 ms low
// - Alternate variant disables channel, indicator stays high
// - Short detection only while some pin regulates
// - Sinks on only when activate and gate high; here the sinks are also on for the lead time after either falls
// - Gate rise starts boost, sinks after lead time
// - Gate fall keeps boost and sinks for lead time
`ifndef LED_DIM_REGS_SVH
`define LED_DIM_REGS_SVH
`define CLK_MHZ            250
`define LOW_TIMEOUT_US     16000
`define LOW_TIMEOUT_CYC    (`LOW_TIMEOUT_US * `CLK_MHZ)
`define LEAD_NS            3000
`define LEAD_CYC           ((`LEAD_NS * `CLK_MHZ) / 1000)
`define SETTLE_US          500
`define SETTLE_CYC         ((`SETTLE_US * `CLK_MHZ) / 8)
`define TRIM_WIN_CYC       6250
`define SOFT_START_CYC     1024
`define CLK_MIRROR_HALF    63
`define HOST_TRIM_PERIOD   1250
`endif

// ==== hw/led_dim_pkg.sv ====
// Types shared by the LED dimming control ends
package led_dim_pkg;
	typedef logic [3:0]  chan_t;
	typedef logic [7:0]  level_t;
	typedef logic [15:0] win_t;
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_IDLE  = 2'b01,
		ST_SOFT  = 2'b10,
		ST_RUN   = 2'b11
	} pwr_state_t;
endpackage

// ==== hw/led_dim_if.sv ====
// Pin bundle between host controller and LED driver control
interface led_dim_if;
	logic chip_activate;
	logic dim_gate;
	logic analog_trim_pulse_input;
	logic fault_n_out;
	logic fault_n_oe;
	logic fault_n;
	logic clock_mirror_output;
	// Open-drain indicator with pull-up
	assign fault_n = fault_n_oe ? fault_n_out : 1'b1;
	modport device (
		input  chip_activate, dim_gate, analog_trim_pulse_input, fault_n,
		output fault_n_out, fault_n_oe, clock_mirror_output
	);
	modport host (
		output chip_activate, dim_gate, analog_trim_pulse_input,
		input  fault_n, clock_mirror_output
	);
endinterface

// ==== hw/led_dim_host.sv ====
// Host end: drives activate, gate and trim pulses, reads indicator
`include "led_dim_regs.svh"
module led_dim_host (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Pins
	led_dim_if.host           pins,
	// User side
	input  wire logic         activate_req,
	input  wire logic         gate_req,
	input  wire led_dim_pkg::level_t trim_duty_pct,
	output logic              fault_seen,
	output logic              mirror_level
);
	import led_dim_pkg::*;
	logic [10:0] per_r;
	logic [17:0] high_cyc;
	logic        trim_r;
	logic        act_r;
	logic        gate_r;
	logic [1:0]  flt_s;
	logic [1:0]  mir_s;
	// Trim high time from duty, capped at 90 percent
	wire  [7:0]  duty_cap = (trim_duty_pct > 8'h5A) ? 8'h5A : trim_duty_pct;
	// Round high time up so the window measurement floors to the duty
	assign high_cyc = 18'((32'(duty_cap) * `HOST_TRIM_PERIOD + 99) / 100);
	// Trim pulse train at 200 kHz, 12.5 cycles per percent step
	always_ff @(posedge core_clk) begin
		if (rst) begin
			per_r  <= '0;
			trim_r <= 1'b0;
			act_r  <= 1'b0;
			gate_r <= 1'b0;
		end else begin
			per_r  <= (per_r == 11'(`HOST_TRIM_PERIOD - 1)) ? '0 : per_r + 11'h001;
			trim_r <= 18'(per_r) < high_cyc;
			act_r  <= activate_req;
			gate_r <= gate_req;
		end
	end
	// Synchronise inputs from the device
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flt_s <= 2'b11;
			mir_s <= 2'b00;
		end else begin
			flt_s <= {flt_s[0], pins.fault_n};
			mir_s <= {mir_s[0], pins.clock_mirror_output};
		end
	end
	assign pins.chip_activate           = act_r;
	assign pins.dim_gate                = gate_r;
	assign pins.analog_trim_pulse_input = trim_r;
	assign fault_seen   = ~flt_s[1];
	assign mirror_level = mir_s[1];
endmodule

// ==== dv/led_dim_chk.sv ====
// Checker on the dimming pins and device power outputs
module led_dim_chk
	import led_dim_pkg::*;
#(
	parameter int LOW_TIMEOUT = 2000
) (
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    rst,
	// Pins
	input wire logic                    chip_activate,
	input wire logic                    dim_gate,
	input wire logic                    fault_n,
	input wire logic                    clock_mirror_output,
	// Device outputs
	input wire led_dim_pkg::chan_t      sink_en,
	input wire logic                    boost_en,
	input wire logic                    bias_en,
	input wire led_dim_pkg::pwr_state_t pwr_state
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_a, cnt_g, cnt_h, cnt_m;
	// Low, high and mirror stability counters
	always_ff @(posedge core_clk) begin
		cnt_a <= (rst || chip_activate) ? 0 : cnt_a + 1;
		cnt_g <= (rst || dim_gate) ? 0 : cnt_g + 1;
		cnt_h <= (rst || !(chip_activate && dim_gate)) ? 0 : cnt_h + 1;
		cnt_m <= (rst || !chip_activate || pwr_state == ST_SLEEP ||
			$changed(clock_mirror_output)) ? 0 : cnt_m + 1; // Mirror only owed while activate high
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_sink_gating: assert property ($rose(|sink_en) |-> chip_activate && dim_gate)
		else $error("sinks on without both controls");
	a_lead_delay: assert property ($rose(|sink_en) |-> cnt_h inside {[745:770]})
		else $error("sink start off the lead time");
	a_fall_hold: assert property (($fell(boost_en) || $fell(|sink_en)) && chip_activate
		|-> cnt_g inside {[745:770]}) else $error("stage dropped off the lead time");
	a_fault_hold: assert property (!fault_n && cnt_a < LOW_TIMEOUT - 8 &&
		cnt_g < LOW_TIMEOUT - 8 |=> !fault_n) else $error("indicator released early");
	a_fault_clear: assert property (cnt_a > LOW_TIMEOUT + 8 || cnt_g > LOW_TIMEOUT + 8
		|-> fault_n) else $error("indicator held after long low");
	a_sleep_entry: assert property (cnt_a > LOW_TIMEOUT + 8
		|-> pwr_state == ST_SLEEP && sink_en == '0 && !boost_en) else $error("no sleep");
	a_gate_clear: assert property (cnt_g > LOW_TIMEOUT + 8 && $past(chip_activate, 8)
		&& chip_activate |-> pwr_state == ST_IDLE) else $error("gate clear not idle");
	a_bias_mirror: assert property (pwr_state != ST_SLEEP |-> bias_en && cnt_m < 70)
		else $error("bias or mirror stopped while awake");
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench joining host and device ends
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import led_dim_pkg::*;
	localparam int LOW = 2000;
	logic core_clk = 0, rst = 1, act = 0, gate = 0, sel = 0, take = 0;
	logic fault_seen, mirror_level, boost_en, bias_en, soft_start;
	level_t duty = 0, current_pct, exp_v;
	level_t tbl[4] = '{8'h00, 8'h19, 8'h5a, 8'h00};
	chan_t above = 0, in_reg = 0, sink_en;
	pwr_state_t pwr_state;
	int n_mismatch = 0, comparisons = 0, k;
	logic [7:0] q[$];
	wire [7:0] obs = sel ? current_pct : {1'b0, fault_seen, pwr_state, sink_en};
	led_dim_if pins ();
	always #2 core_clk = ~core_clk;
	led_dim_host led_dim_host_i (.core_clk, .rst, .pins, .activate_req(act), .gate_req(gate),
		.trim_duty_pct(duty), .fault_seen, .mirror_level);
	led_dim_dev #(.LOW_TIMEOUT(LOW), .SETTLE(1000)) led_dim_dev_i (.core_clk, .rst, .pins,
		.pin_above_short(above), .pin_in_reg(in_reg), .sink_en, .boost_en, .bias_en,
		.soft_start, .current_pct, .pwr_state);
	led_dim_chk #(.LOW_TIMEOUT(LOW)) led_dim_chk_i (.core_clk, .rst,
		.chip_activate(pins.chip_activate), .dim_gate(pins.dim_gate), .fault_n(pins.fault_n),
		.clock_mirror_output(pins.clock_mirror_output), .sink_en, .boost_en, .bias_en,
		.pwr_state);
	// Oldest note against the selected outputs
	always @(posedge core_clk) if (take) begin
		exp_v = q.pop_front();
		comparisons++;
		if (obs !== exp_v) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, obs, exp_v);
		end
	end
	task automatic run(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic note(input logic s, input logic [7:0] e);
		q.push_back(e);
		sel <= s;
		take <= 1;
		@(posedge core_clk);
		take <= 0;
		@(posedge core_clk);
	endtask
	// Bounded wait for sinks on or for a current level, then note
	task automatic hold_until(input logic s, input logic [7:0] e, input int lim);
		for (k = 0; k < lim && (s ? current_pct !== e : sink_en === 4'h0); k++) run(1);
		if (k == lim) begin
			n_mismatch++;
			complete_run();
		end else begin
			note(s, e);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence
	initial begin
		k = $urandom(14);
		tbl[3] = level_t'($urandom % 91);
		run(5);
		rst <= 0;
		run(3);
		note(0, {2'b00, ST_SLEEP, 4'h0});
		note(1, 8'h64);
		$display("reset test done");
		act <= 1;
		gate <= 1;
		hold_until(0, {2'b00, ST_SOFT, 4'hf}, 2000);
		run(400);
		above <= 4'h2;
		run(20);
		note(0, {2'b00, ST_RUN, 4'hf});
		in_reg <= 4'h1;
		run(20);
		above <= 4'h0;
		run(20);
		note(0, {2'b01, ST_RUN, 4'hd});
		gate <= 0;
		run(1000);
		gate <= 1;
		hold_until(0, {2'b01, ST_RUN, 4'hd}, 2000);
		$display("short test done");
		gate <= 0;
		run(LOW + 20);
		note(0, {2'b00, ST_IDLE, 4'h0});
		gate <= 1;
		hold_until(0, {2'b00, ST_SOFT, 4'hf}, 2000);
		above <= 4'h4;
		run(20);
		above <= 4'h0;
		note(0, {2'b01, ST_SOFT, 4'hb});
		act <= 0;
		run(LOW + 20);
		note(0, {2'b00, ST_SLEEP, 4'h0});
		act <= 1;
		hold_until(0, {2'b00, ST_SOFT, 4'hf}, 2000);
		$display("clear test done");
		for (int j = 0; j < 4; j++) begin
			duty <= tbl[j];
			hold_until(1, 8'h64 - tbl[j], 14000);
		end
		$display("trim test done");
		complete_run();
	end
endmodule
